// ===== rtl/paef_defines.vh
`ifndef PAEF_DEFINES_VH
`define PAEF_DEFINES_VH

// Register indices as printed; byte address is four times the index
`define PAEF_IDX_EXP        6'h06
`define PAEF_IDX_FUNC       6'h10
`define PAEF_ADDR_EXP       8'h18
`define PAEF_ADDR_FUNC      8'h40
`define PAEF_ADDR_CTRL      8'h80
`define PAEF_ADDR_IRQ_STAT  8'h84
`define PAEF_ADDR_IRQ_MASK  8'h88
`define PAEF_ADDR_PHY_STAT  8'h8C

// Expansion register fields
`define PAEF_EXP_PDF        4
`define PAEF_EXP_RSV3       3
`define PAEF_EXP_RSV2       2
`define PAEF_EXP_PAGE       1
`define PAEF_EXP_LPAN       0
`define PAEF_EXP_RSV2_RST   1'b1

// Function control fields
`define PAEF_FC_CRS         11
`define PAEF_FC_ED_HI       9
`define PAEF_FC_ED_LO       8
`define PAEF_FC_MDIX_HI     6
`define PAEF_FC_MDIX_LO     5
`define PAEF_FC_SQE         2
`define PAEF_FC_POL         1
`define PAEF_FC_JAB         0
`define PAEF_FC_WMASK       16'h0B67
`define PAEF_FC_RST         16'h0060
`define PAEF_MDIX_RST       2'b11
`define PAEF_MDIX_MDI       2'b00
`define PAEF_MDIX_MDIX      2'b01
`define PAEF_MDIX_AUTO      2'b11

// Control register: bit 0 software reset (self-clearing)
`define PAEF_CTRL_SWRST     0

// Interrupt status bits
`define PAEF_IRQ_PDF        0
`define PAEF_IRQ_PAGE       1
`define PAEF_IRQ_LPAN       2

`define PAEF_RESP_OKAY      2'b00
`define PAEF_RESP_SLVERR    2'b10

`endif

// ===== rtl/paef_regs.v
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "paef_defines.vh"

module paef_regs (
    // Clock and reset
    input  wire        mclk,
    input  wire        arst_n,
    // AXI4-Lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Status from the transceiver core
    input  wire        pd_fault,
    input  wire        page_rx,
    input  wire        lp_an_able,
    input  wire        full_duplex,
    input  wire        link_10bt,
    // Control to the transceiver core
    output reg  [1:0]  energy_detect_mode,
    output reg         nlp_tx_en,
    output reg  [1:0]  mdix_mode,
    output reg         sqe_test_en,
    output reg         polarity_corr_en,
    output reg         jabber_en,
    output reg         crs_on_tx,
    output reg         sw_reset,
    // Interrupt
    output wire        irq
);

    reg        rst_s1;
    reg        rst_s2;
    wire [2:0] in_s2;
    wire [1:0] dpx_s2;
    reg  [2:0] in_d;
    reg        exp_pdf;
    reg        exp_page;
    reg        exp_rsv2;
    reg  [15:0] func;
    reg  [1:0] mdix_live;
    reg  [2:0] irq_stat;
    reg  [2:0] irq_mask;
    reg  [7:0] aw_addr;
    reg        aw_have;
    reg  [31:0] w_data;
    reg  [3:0] w_strb;
    reg        w_have;
    reg  [15:0] next_func;

    wire rst_n = rst_s2;
    wire pdf_s = in_s2[0];
    wire page_s = in_s2[1];
    wire lpan_s = in_s2[2];
    wire fdx_s = dpx_s2[0];
    wire l10_s = dpx_s2[1];
    // A write lands once address and data are held and the last answer left
    wire do_wr = aw_have && w_have && !s_axi_bvalid;
    wire do_rd = s_axi_arvalid && !s_axi_rvalid;
    wire rd_exp = do_rd && (s_axi_araddr == `PAEF_ADDR_EXP);
    wire [15:0] exp_val = {11'h000,
                           exp_pdf,
                           1'b0,
                           exp_rsv2,
                           exp_page,
                           lpan_s};
    wire [2:0] ev_rise = in_s2 & ~in_d;
    wire [15:0] wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};

    // Ready drops while a word is held, so a second beat cannot overwrite it
    assign s_axi_awready = !aw_have;
    assign s_axi_wready  = !w_have;
    assign s_axi_arready = !s_axi_rvalid;
    assign irq = |(irq_stat & irq_mask);

    // Reset release synchroniser
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    // Pin input synchronisers
    paef_sync2 #(
        .WIDTH (3)
    ) in_sync_inst (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     ({lp_an_able, page_rx, pd_fault}),
        .q     (in_s2)
    );

    paef_sync2 #(
        .WIDTH (2)
    ) dpx_sync_inst (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     ({link_10bt, full_duplex}),
        .q     (dpx_s2)
    );

    // Previous synchronised level, for rise detection
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            in_d <= 3'h0;
        end else begin
            in_d <= in_s2;
        end
    end

    // Function control write data, fixed-zero bits masked
    always @* begin
        next_func = func;
        if (do_wr && aw_addr == `PAEF_ADDR_FUNC)
            next_func = (func & ~(wmask & `PAEF_FC_WMASK)) |
                        (w_data[15:0] & wmask & `PAEF_FC_WMASK);
    end

    // Register state
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            func      <= `PAEF_FC_RST;
            mdix_live <= `PAEF_MDIX_RST;
            exp_pdf   <= 1'b0;
            exp_page  <= 1'b0;
            exp_rsv2  <= `PAEF_EXP_RSV2_RST;
            irq_stat  <= 3'h0;
            irq_mask  <= 3'h0;
            sw_reset  <= 1'b0;
        end else begin
            func     <= next_func;
            sw_reset <= do_wr && aw_addr == `PAEF_ADDR_CTRL &&
                        w_strb[0] && w_data[`PAEF_CTRL_SWRST];
            if (sw_reset) begin
                // Retained fields kept; crossover takes the written value
                mdix_live <= func[`PAEF_FC_MDIX_HI:`PAEF_FC_MDIX_LO];
                // An event in the reset cycle still latches
                exp_pdf   <= pdf_s;
                exp_page  <= page_s;
                exp_rsv2  <= `PAEF_EXP_RSV2_RST;
            end else begin
                // Set wins over the clear by read
                exp_pdf  <= pdf_s | (exp_pdf & ~rd_exp);
                exp_page <= page_s | (exp_page & ~rd_exp);
                if (do_wr && aw_addr == `PAEF_ADDR_EXP && w_strb[0])
                    exp_rsv2 <= w_data[`PAEF_EXP_RSV2];
            end
            if (do_wr && aw_addr == `PAEF_ADDR_IRQ_MASK && w_strb[0])
                irq_mask <= w_data[2:0];
            // A rise sets, a written one clears; the rise wins
            if (do_wr && aw_addr == `PAEF_ADDR_IRQ_STAT && w_strb[0])
                irq_stat <= ev_rise | (irq_stat & ~w_data[2:0]);
            else
                irq_stat <= irq_stat | ev_rise;
        end
    end

    // Decoded controls to the core
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            energy_detect_mode <= 2'b00;
            nlp_tx_en          <= 1'b0;
            mdix_mode          <= `PAEF_MDIX_RST;
            sqe_test_en        <= 1'b0;
            polarity_corr_en   <= 1'b1;
            jabber_en          <= 1'b1;
            crs_on_tx          <= 1'b0;
        end else begin
            // 0x off, 10 receive sense, 11 sense plus NLP
            energy_detect_mode <= func[`PAEF_FC_ED_HI] ?
                func[`PAEF_FC_ED_HI:`PAEF_FC_ED_LO] : 2'b00;
            nlp_tx_en <= func[`PAEF_FC_ED_HI] & func[`PAEF_FC_ED_LO];
            mdix_mode <= mdix_live;
            // Full duplex overrides the SQE enable bit
            sqe_test_en <= func[`PAEF_FC_SQE] & ~fdx_s;
            polarity_corr_en <= ~func[`PAEF_FC_POL];
            jabber_en <= ~(func[`PAEF_FC_JAB] & l10_s & ~fdx_s);
            crs_on_tx <= func[`PAEF_FC_CRS];
        end
    end

    // AXI4-Lite write channel
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have      <= 1'b0;
            aw_addr      <= 8'h00;
            w_have       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PAEF_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_have) begin
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_have) begin
                w_have <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_have      <= 1'b0;
                w_have       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr)
                    `PAEF_ADDR_EXP, `PAEF_ADDR_FUNC, `PAEF_ADDR_CTRL,
                    `PAEF_ADDR_IRQ_STAT, `PAEF_ADDR_IRQ_MASK,
                    `PAEF_ADDR_PHY_STAT: s_axi_bresp <= `PAEF_RESP_OKAY;
                    default: s_axi_bresp <= `PAEF_RESP_SLVERR;
                endcase
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel
    // Data are captured at the accept edge and held until taken
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `PAEF_RESP_OKAY;
        end else if (do_rd) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `PAEF_RESP_OKAY;
            case (s_axi_araddr)
                `PAEF_ADDR_EXP:      s_axi_rdata <= {16'h0000, exp_val};
                `PAEF_ADDR_FUNC:     s_axi_rdata <= {16'h0000, func};
                `PAEF_ADDR_CTRL:     s_axi_rdata <= 32'h0000_0000;
                `PAEF_ADDR_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat};
                `PAEF_ADDR_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask};
                `PAEF_ADDR_PHY_STAT: s_axi_rdata <= {27'h0, l10_s, fdx_s,
                                                     mdix_live, irq};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `PAEF_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// Two-flop synchroniser for inputs from outside the clock domain
module paef_sync2 #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             mclk,
    input  wire             rst_n,
    // Asynchronous input and its synchronised copy
    input  wire [WIDTH-1:0] d,
    output reg  [WIDTH-1:0] q
);

    reg [WIDTH-1:0] meta;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= {WIDTH{1'b0}};
            q    <= {WIDTH{1'b0}};
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule
`default_nettype wire

// ===== verif/paef_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module paef_core_model (
    // Clock
    input  wire logic mclk,
    // Status lines toward the register block
    output var  logic pd_fault,
    output var  logic page_rx,
    output var  logic lp_an_able,
    output var  logic full_duplex,
    output var  logic link_10bt
);
    initial {pd_fault, page_rx, lp_an_able, full_duplex, link_10bt} = 5'h00;

    // Order: fault, page, able, full duplex, 10BASE-T
    task drive(input logic [4:0] v);
        @(posedge mclk);
        {pd_fault, page_rx, lp_an_able, full_duplex, link_10bt} <= v;
    endtask
endmodule
`default_nettype wire

// ===== verif/paef_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module paef_regs_props (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       arst_n,
    // Bus handshakes
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    // Core status and controls
    input wire logic       full_duplex,
    input wire logic       link_10bt,
    input wire logic [1:0] energy_detect_mode,
    input wire logic       nlp_tx_en,
    input wire logic [1:0] mdix_mode,
    input wire logic       sqe_test_en,
    input wire logic       jabber_en,
    input wire logic       sw_reset
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    chk_sqe_fdx: assert property (
        full_duplex [*4] |-> !sqe_test_en) else $error("sqe in full duplex");
    chk_jab_not10: assert property (
        (!link_10bt) [*4] |-> jabber_en) else $error("jabber off not 10bt");
    chk_jab_fdx: assert property (
        full_duplex [*4] |-> jabber_en) else $error("jabber off full dup");
    chk_nlp_mode: assert property (
        nlp_tx_en == (energy_detect_mode == 2'b11)) else $error("nlp mode");
    chk_mdix_swrst: assert property (
        $changed(mdix_mode) |-> sw_reset || $past(sw_reset)
        || $past(sw_reset, 2)) else $error("mdix moved without reset");
    chk_swrst_pulse: assert property (
        sw_reset |=> !sw_reset) else $error("sw reset too long");
    chk_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("no write response");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read response");

    cover property (sw_reset);
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind paef_regs paef_regs_props paef_regs_props_inst (
    .mclk               (mclk),
    .arst_n             (arst_n),
    .s_axi_awvalid      (s_axi_awvalid),
    .s_axi_awready      (s_axi_awready),
    .s_axi_wvalid       (s_axi_wvalid),
    .s_axi_wready       (s_axi_wready),
    .s_axi_bvalid       (s_axi_bvalid),
    .s_axi_bready       (s_axi_bready),
    .s_axi_arvalid      (s_axi_arvalid),
    .s_axi_arready      (s_axi_arready),
    .s_axi_rvalid       (s_axi_rvalid),
    .s_axi_rready       (s_axi_rready),
    .full_duplex        (full_duplex),
    .link_10bt          (link_10bt),
    .energy_detect_mode (energy_detect_mode),
    .nlp_tx_en          (nlp_tx_en),
    .mdix_mode          (mdix_mode),
    .sqe_test_en        (sqe_test_en),
    .jabber_en          (jabber_en),
    .sw_reset           (sw_reset)
);
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire         s_axi_rvalid, irq, nlp_tx_en, sqe_test_en, sw_reset;
    wire         polarity_corr_en, jabber_en, crs_on_tx;
    wire [1:0]   s_axi_bresp, s_axi_rresp, energy_detect_mode, mdix_mode;
    wire [31:0]  s_axi_rdata;
    wire         pd_fault, page_rx, lp_an_able, full_duplex, link_10bt;
    int          miscompares = 0;
    int          n_tests = 0;
    logic [31:0] d;
    logic [1:0]  r;

    paef_regs paef_regs_inst (
        .mclk               (mclk),
        .arst_n             (arst_n),
        .s_axi_awaddr       (s_axi_awaddr),
        .s_axi_awvalid      (s_axi_awvalid),
        .s_axi_awready      (s_axi_awready),
        .s_axi_wdata        (s_axi_wdata),
        .s_axi_wstrb        (s_axi_wstrb),
        .s_axi_wvalid       (s_axi_wvalid),
        .s_axi_wready       (s_axi_wready),
        .s_axi_bresp        (s_axi_bresp),
        .s_axi_bvalid       (s_axi_bvalid),
        .s_axi_bready       (s_axi_bready),
        .s_axi_araddr       (s_axi_araddr),
        .s_axi_arvalid      (s_axi_arvalid),
        .s_axi_arready      (s_axi_arready),
        .s_axi_rdata        (s_axi_rdata),
        .s_axi_rresp        (s_axi_rresp),
        .s_axi_rvalid       (s_axi_rvalid),
        .s_axi_rready       (s_axi_rready),
        .pd_fault           (pd_fault),
        .page_rx            (page_rx),
        .lp_an_able         (lp_an_able),
        .full_duplex        (full_duplex),
        .link_10bt          (link_10bt),
        .energy_detect_mode (energy_detect_mode),
        .nlp_tx_en          (nlp_tx_en),
        .mdix_mode          (mdix_mode),
        .sqe_test_en        (sqe_test_en),
        .polarity_corr_en   (polarity_corr_en),
        .jabber_en          (jabber_en),
        .crs_on_tx          (crs_on_tx),
        .sw_reset           (sw_reset),
        .irq                (irq)
    );
    paef_core_model paef_core_model_inst (
        .mclk        (mclk),
        .pd_fault    (pd_fault),
        .page_rx     (page_rx),
        .lp_an_able  (lp_an_able),
        .full_duplex (full_duplex),
        .link_10bt   (link_10bt)
    );

    always #10 mclk = ~mclk;

    task end_sim;
        if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task chk(input string s, input logic [31:0] seen, input logic [31:0] e);
        n_tests++;
        if (seen !== e) begin
            miscompares++;
            $display("mismatch %s exp %h seen %h", s, e, seen);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] v,
            input logic [1:0] er = 2'b00);
        logic       ka, kw, kb;
        logic [1:0] br;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        repeat (40) begin
            @(negedge mclk);
            ka = s_axi_awvalid && s_axi_awready;
            kw = s_axi_wvalid && s_axi_wready;
            kb = s_axi_bvalid;
            br = s_axi_bresp;
            @(posedge mclk);
            if (ka) s_axi_awvalid <= 1'b0;
            if (kw) s_axi_wvalid <= 1'b0;
            if (kb) begin
                s_axi_bready <= 1'b0;
                chk("bresp", br, er);
                return;
            end
        end
        miscompares++;
        end_sim;
    endtask

    task rchk(input string s, input logic [7:0] a, input logic [31:0] e,
              input logic [1:0] er);
        logic ka, kr;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        repeat (40) begin
            @(negedge mclk);
            ka = s_axi_arvalid && s_axi_arready;
            kr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge mclk);
            if (ka) s_axi_arvalid <= 1'b0;
            if (kr) begin
                s_axi_rready <= 1'b0;
                chk(s, d, e);
                chk({s, "_resp"}, r, er);
                return;
            end
        end
        miscompares++;
        end_sim;
    endtask

    task t_reset;
        rchk("exp_rst", 8'h18, 16'h0004, 2'b00);
        rchk("func_rst", 8'h40, 16'h0060, 2'b00);
        chk("mdix_rst", mdix_mode, 2'b11);
        rchk("unmapped", 8'hFC, 32'h0000_0000, 2'b10);
        wr(8'hFC, 32'h0000_0000, 2'b10);
    endtask

    task t_flags;
        paef_core_model_inst.drive(5'b11100);
        paef_core_model_inst.drive(5'b00100);
        repeat (5) @(negedge mclk);
        chk("irq_masked", irq, 1'b0);
        rchk("exp_lh", 8'h18, 16'h0017, 2'b00);
        rchk("exp_clr", 8'h18, 16'h0005, 2'b00);
        wr(8'h88, 16'h0001);
        @(negedge mclk);
        chk("irq_on", irq, 1'b1);
        wr(8'h84, 16'h0001);
        @(negedge mclk);
        chk("irq_off", irq, 1'b0);
        rchk("irq_stat", 8'h84, 16'h0006, 2'b00);
        paef_core_model_inst.drive(5'b10100);
        repeat (5) @(negedge mclk);
        rchk("exp_hold", 8'h18, 16'h0015, 2'b00);
        rchk("exp_hold2", 8'h18, 16'h0015, 2'b00);
        paef_core_model_inst.drive(5'b00111);
    endtask

    task t_func;
        wr(8'h40, 16'hFF9F);
        repeat (4) @(negedge mclk);
        rchk("func_wr", 8'h40, 16'h0B07, 2'b00);
        chk("mdix_hold", mdix_mode, 2'b11);
        chk("sqe_fdx", sqe_test_en, 1'b0);
        chk("pol_off", polarity_corr_en, 1'b0);
        chk("jab_fdx", jabber_en, 1'b1);
        chk("crs_on", crs_on_tx, 1'b1);
        paef_core_model_inst.drive(5'b00101);
        repeat (5) @(negedge mclk);
        chk("sqe_hdx", sqe_test_en, 1'b1);
        chk("jab_hdx", jabber_en, 1'b0);
        for (int i = 0; i < 4; i++) begin
            wr(8'h40, {i[1:0], 8'h06});
            repeat (4) @(negedge mclk);
            chk("ed", energy_detect_mode, i[1] ? i[1:0] : 2'b00);
            chk("nlp", nlp_tx_en, i == 3);
            chk("crs_off", crs_on_tx, 1'b0);
        end
    endtask

    task t_swrst;
        wr(8'h18, 32'h0000_0000);
        rchk("exp_rsv", 8'h18, 16'h0011, 2'b00);
        for (int m = 0; m < 2; m++) begin
            wr(8'h40, {2'b11, 2'b00, m[0], 5'h05});
            wr(8'h80, 16'h0001);
            repeat (4) @(negedge mclk);
            chk("mdix_sw", mdix_mode, {1'b0, m[0]});
            chk("pol_on", polarity_corr_en, 1'b1);
            chk("ed_keep", energy_detect_mode, 2'b11);
            rchk("func_sw", 8'h40, {2'b11, 2'b00, m[0], 5'h05}, 2'b00);
        end
        rchk("exp_sw", 8'h18, 16'h0005, 2'b00);
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        t_reset;
        t_flags;
        t_func;
        t_swrst;
        end_sim;
    end
endmodule
`default_nettype wire
